//--- rtl/ddp_cfg.svh
// timing counts, reset levels and pin field positions for the ddr2 pin block
// assumes a 125 MHz system clock; included by bare name
`ifndef DDP_CFG_SVH
`define DDP_CFG_SVH
`define DDP_SYS_PERIOD_NS 8
`define DDP_MCK_HALF_NS 80
`define DDP_MCK_HALF_CYC ((`DDP_MCK_HALF_NS + `DDP_SYS_PERIOD_NS - 1) / `DDP_SYS_PERIOD_NS)
`define DDP_WL_CK 2
`define DDP_RD_TIMEOUT_CK 8
`define DDP_CS_IDLE 4'h0f
`define DDP_LANE0_LSB 0
`define DDP_LANE1_LSB 8
`define DDP_LANE_W 8
`endif

//--- rtl/ddp_ctrl.sv
// ddr2 pin sequencer: memory clocks, command pins, write and read data lanes
// assumes the user holds a command stable until acknowledged; pad logic resolves the enables
// Operation
// R1 - chip select high masks every command
// R2 - four active-low selects decoded from index
// R3 - data mask high drops lane write
// R4 - memory samples masks on both strobe edges
// R5 - mask 0 low byte, mask 1 high
// R6 - strobe 0 low byte, strobe 1 high
// R7 - strobe out with writes, in with reads
// R8 - strobes single-ended or differential by setting
// R9 - three-bit bank address per command
// R10 - bank address picks mode register on load
// R11 - row, column, write strobes encode operation
// R12 - clock enable active high, low in reset
// R13 - two differential memory clocks, software enabled
// R14 - termination driven independent of commands
// R15 - sixteen-bit address, low in reset
// R16 - sixteen-bit data bus released in reset
// R17 - standard encoding, sampled at rising clock
`timescale 1ns/100ps
`include "ddp_cfg.svh"
module ddp_ctrl
	import ddp_pkg::*;
#(
	parameter int WL_CK = `DDP_WL_CK,
	parameter int RD_TIMEOUT_CK = `DDP_RD_TIMEOUT_CK,
	parameter int FIFO_DEPTH = 8
) (
	input wire logic clk_sys_i, // system clock
	input wire logic sys_rst_i, // sync reset, active high
	input wire logic mck_en_i, // memory clock enable setting
	input wire logic strobe_diff_i, // differential strobe setting
	input wire logic cke_en_i, // request clock enable high
	input wire logic odt_en_i, // request termination on
	input wire logic cmd_valid_i, // command request
	input wire ddp_cmd_t cmd_i, // command fields
	output logic cmd_ack_o, // command taken pulse
	input wire logic wr_valid_i, // write beat valid
	input wire ddp_wbeat_t wr_i, // write beat
	output logic wr_ready_o, // write fifo ready
	output logic rd_valid_o, // read pair pulse
	output logic [31:0] rd_data_o, // {second beat, first beat}
	output logic rd_timeout_o, // read strobes missing pulse
	output logic [1:0] mck_o, // memory clocks, true side
	output logic [1:0] mck_n_o, // memory clocks, complement
	output logic mck_oe_o, // memory clock drive
	output logic [3:0] cs_n_o, // chip selects
	output logic ras_n_o, // row strobe
	output logic cas_n_o, // column strobe
	output logic we_n_o, // write enable
	output logic [2:0] ba_o, // bank address
	output logic [15:0] addr_o, // address bus
	output logic ctl_oe_o, // command/address drive
	output logic cke_o, // clock enable
	output logic odt_o, // on-die termination
	output logic [15:0] dq_o, // data out
	output logic dq_oe_o, // data drive
	input wire logic [15:0] dq_i, // data pins in
	output logic [1:0] dm_o, // data masks
	output logic [1:0] dqs_o, // strobes, true side
	output logic [1:0] dqs_n_o, // strobes, complement
	output logic dqs_oe_o, // true strobe drive
	output logic dqs_n_oe_o, // complement strobe drive
	input wire logic [1:0] dqs_i, // strobe pins in
	input wire logic [1:0] dqs_n_i // complement strobe pins in
);
	localparam int HALF = `DDP_MCK_HALF_CYC; // system cycles per clock half
	localparam int DW = $clog2(HALF);
	localparam int LW = $clog2(FIFO_DEPTH + 1);

	// command pin encoding {ras,cas,we}
	function automatic logic [2:0] ddp_op_code(input ddp_op_t op);
		logic [2:0] c;
		c = 3'h7;
		unique case (op)
			DDP_OP_ACT: c = 3'h3;
			DDP_OP_RD: c = 3'h5;
			DDP_OP_WR: c = 3'h4;
			DDP_OP_PRE: c = 3'h2;
			DDP_OP_REF: c = 3'h1;
			DDP_OP_LMR: c = 3'h0;
			default: c = 3'h7;
		endcase
		return c;
	endfunction : ddp_op_code

	// one low select line for a bank index
	function automatic logic [3:0] ddp_cs_dec(input logic [1:0] sel);
		return ~(4'h1 << sel);
	endfunction : ddp_cs_dec

	ddp_state_t st_q; // sequencer state
	logic [DW-1:0] div_q; // clock half divider
	logic tick; // clock half boundary
	logic fall; // memory clock about to fall
	logic mck_q; // memory clock level
	ddp_op_t op_q; // operation in flight
	logic [3:0] lat_q; // write latency countdown
	logic [2:0] wph_q; // write beat phase
	logic [3:0] rto_q; // read timeout count
	logic pop; // take a beat from the fifo
	logic fifo_valid; // fifo head valid
	ddp_wbeat_t fifo_data; // fifo head
	logic [LW-1:0] fifo_level; // beats buffered
	logic [19:0] pin_s; // synchronised dq and strobes
	logic [1:0] lane_stb; // strobe level per lane
	logic [1:0] lane_prev_q; // previous strobe level
	logic [1:0] edge_cnt_q [2]; // edges seen per lane
	logic [31:0] rbuf_q; // captured beats
	logic cap_q; // capture window open
	logic rd_done; // both lanes saw two edges
	logic can_issue; // command may launch now

	assign tick = (div_q == DW'(HALF - 1));
	assign fall = tick && mck_q;

	// clock half divider
	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
			div_q <= '0;
		else
			div_q <= tick ? '0 : div_q + 1'b1;
	end

	// free running memory clock, gated by the software enable
	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
		begin
			mck_q <= 1'b0;
			mck_o <= 2'b00;
			mck_n_o <= 2'b00;
			mck_oe_o <= 1'b0;
		end
		else
		begin
			mck_oe_o <= mck_en_i; // see R13
			if (!mck_en_i)
			begin
				// parked pair stays complementary, so the first driven cycle is a true pair
				mck_q <= 1'b0;
				mck_o <= 2'b00;
				mck_n_o <= 2'b11;
			end
			else if (tick)
			begin
				mck_q <= ~mck_q;
				mck_o <= {2{!mck_q}}; // see R13
				mck_n_o <= {2{mck_q}}; // see R13
			end
		end
	end

	// clock enable and termination follow their settings only
	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
		begin
			cke_o <= 1'b0; // see R12
			odt_o <= 1'b0;
			ctl_oe_o <= 1'b0;
		end
		else
		begin
			cke_o <= cke_en_i; // see R12
			odt_o <= odt_en_i; // see R14
			ctl_oe_o <= 1'b1;
		end
	end

	// write beat buffer
	ddp_fifo #(
		.W($bits(ddp_wbeat_t)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.in_valid_i(wr_valid_i),
		.in_ready_o(wr_ready_o),
		.in_data_i(wr_i),
		.out_valid_o(fifo_valid),
		.out_ready_i(pop),
		.out_data_o(fifo_data),
		.level_o(fifo_level)
	);

	// pin inputs from the memory side
	ddp_sync #(
		.W(20)
	) u_sync (
		.clk_sys_i(clk_sys_i),
		.d_i({dqs_n_i, dqs_i, dq_i}),
		.q_o(pin_s)
	);

	// strobe level per lane, differential mode needs both sides agreeing
	assign lane_stb = strobe_diff_i ? (pin_s[17:16] & ~pin_s[19:18]) : pin_s[17:16]; // see R8
	assign rd_done = (edge_cnt_q[0] == 2'd2) && (edge_cnt_q[1] == 2'd2);
	// writes wait for both beats to be buffered
	assign can_issue = cmd_valid_i && mck_en_i && !cmd_ack_o
		&& ((cmd_i.op != DDP_OP_WR) || (fifo_level >= LW'(2)));
	assign pop = tick && fifo_valid && (((st_q == DDP_ST_WLAT) && (lat_q == 4'h1) && fall)
		|| ((st_q == DDP_ST_WDATA) && (wph_q == 3'd2)));

	// sequencer; command pins change on the falling memory clock
	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
		begin
			st_q <= DDP_ST_IDLE;
			op_q <= DDP_OP_NOP;
			cmd_ack_o <= 1'b0;
			cs_n_o <= `DDP_CS_IDLE;
			{ras_n_o, cas_n_o, we_n_o} <= 3'h7;
			ba_o <= 3'h0;
			addr_o <= 16'h0000; // see R15
			lat_q <= 4'h0;
			rto_q <= 4'h0;
			rd_timeout_o <= 1'b0;
		end
		else
		begin
			cmd_ack_o <= 1'b0;
			rd_timeout_o <= 1'b0;
			unique case (st_q)
				// wait for a request at a falling edge
				DDP_ST_IDLE:
				begin
					if (fall && can_issue)
					begin
						cs_n_o <= ddp_cs_dec(cmd_i.cs_sel); // see R2
						{ras_n_o, cas_n_o, we_n_o} <= ddp_op_code(cmd_i.op); // see R11 R17
						ba_o <= cmd_i.ba; // see R9 R10
						addr_o <= cmd_i.addr;
						op_q <= cmd_i.op;
						cmd_ack_o <= 1'b1;
						st_q <= DDP_ST_CMD;
					end
				end
				// command held for one full clock, then deselect
				DDP_ST_CMD:
				begin
					if (fall)
					begin
						cs_n_o <= `DDP_CS_IDLE; // see R1
						{ras_n_o, cas_n_o, we_n_o} <= 3'h7;
						lat_q <= 4'(WL_CK - 1);
						rto_q <= 4'(RD_TIMEOUT_CK);
						if (op_q == DDP_OP_WR)
							st_q <= DDP_ST_WLAT;
						else if (op_q == DDP_OP_RD)
							st_q <= DDP_ST_RWAIT;
						else
							st_q <= DDP_ST_IDLE;
					end
				end
				// write latency in whole clocks
				DDP_ST_WLAT:
				begin
					if (fall)
					begin
						if (lat_q == 4'h1)
							st_q <= DDP_ST_WDATA;
						else
							lat_q <= lat_q - 1'b1;
					end
				end
				// beats run from the phase counter
				DDP_ST_WDATA:
				begin
					if (tick && (wph_q == 3'd4))
						st_q <= DDP_ST_IDLE;
				end
				// collect strobes or give up
				DDP_ST_RWAIT:
				begin
					if (rd_done)
						st_q <= DDP_ST_IDLE;
					else if (fall)
					begin
						if (rto_q == 4'h0)
						begin
							rd_timeout_o <= 1'b1;
							st_q <= DDP_ST_IDLE;
						end
						else
							rto_q <= rto_q - 1'b1;
					end
				end
				default: st_q <= DDP_ST_IDLE;
			endcase
		end
	end

	// write lanes: data, masks and centred strobes
	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
		begin
			wph_q <= 3'd0;
			dq_o <= 16'h0000;
			dq_oe_o <= 1'b0; // see R16
			dm_o <= 2'b00;
			dqs_o <= 2'b00;
			dqs_n_o <= 2'b00;
			dqs_oe_o <= 1'b0;
			dqs_n_oe_o <= 1'b0;
		end
		else if (tick)
		begin
			// first beat launched at the falling edge ending latency
			if ((st_q == DDP_ST_WLAT) && (lat_q == 4'h1) && fall)
			begin
				dq_o <= fifo_data.data;
				dm_o <= fifo_data.mask; // see R3 R5
				dq_oe_o <= 1'b1;
				dqs_o <= 2'b00;
				dqs_n_o <= {2{strobe_diff_i}};
				dqs_oe_o <= 1'b1; // see R7
				dqs_n_oe_o <= strobe_diff_i; // see R8
				wph_q <= 3'd1;
			end
			else if (st_q == DDP_ST_WDATA)
			begin
				wph_q <= wph_q + 1'b1;
				unique case (wph_q)
					// rising strobe on both lanes samples beat one
					3'd1:
					begin
						dqs_o <= 2'b11; // see R4 R6
						dqs_n_o <= 2'b00;
					end
					// second beat
					3'd2:
					begin
						dq_o <= fifo_data.data;
						dm_o <= fifo_data.mask; // see R3 R5
					end
					// falling strobe samples beat two
					3'd3:
					begin
						dqs_o <= 2'b00; // see R4 R6
						dqs_n_o <= {2{strobe_diff_i}};
					end
					// release the lanes
					default:
					begin
						dq_oe_o <= 1'b0;
						dqs_oe_o <= 1'b0;
						dqs_n_oe_o <= 1'b0;
						dqs_n_o <= 2'b00;
						dm_o <= 2'b00;
						wph_q <= 3'd0;
					end
				endcase
			end
		end
	end

	// read capture: each lane is timed by its own strobe
	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
		begin
			cap_q <= 1'b0;
			lane_prev_q <= 2'b00;
			edge_cnt_q[0] <= 2'd0;
			edge_cnt_q[1] <= 2'd0;
			rbuf_q <= 32'h0000_0000;
		end
		else
		begin
			lane_prev_q <= lane_stb;
			cap_q <= (st_q == DDP_ST_RWAIT) && !rd_done;
			if (!cap_q)
			begin
				edge_cnt_q[0] <= 2'd0;
				edge_cnt_q[1] <= 2'd0;
			end
			else
			begin
				for (int l = 0; l < 2; l++)
				begin
					if ((lane_stb[l] != lane_prev_q[l]) && (edge_cnt_q[l] != 2'd2)) // see R7
					begin
						// lane l owns data byte l, beat index from edge count
						rbuf_q[16*edge_cnt_q[l][0] + `DDP_LANE_W*l +: `DDP_LANE_W] <=
							pin_s[`DDP_LANE_W*l +: `DDP_LANE_W]; // see R6
						edge_cnt_q[l] <= edge_cnt_q[l] + 1'b1;
					end
				end
			end
		end
	end

	// hand the read pair to the user
	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
		begin
			rd_valid_o <= 1'b0;
			rd_data_o <= 32'h0000_0000;
		end
		else
		begin
			rd_valid_o <= (st_q == DDP_ST_RWAIT) && rd_done;
			if ((st_q == DDP_ST_RWAIT) && rd_done)
				rd_data_o <= rbuf_q;
		end
	end
endmodule : ddp_ctrl

//--- rtl/ddp_fifo.sv
// write beat fifo with registered output word and registered ready
// assumes one clock and a synchronous active high reset
`timescale 1ns/100ps
module ddp_fifo #(
	parameter int W = 18,
	parameter int DEPTH = 8
) (
	input wire logic clk_sys_i, // system clock
	input wire logic sys_rst_i, // sync reset
	input wire logic in_valid_i, // fill side valid
	output logic in_ready_o, // fill side ready
	input wire logic [W-1:0] in_data_i, // fill data
	output logic out_valid_o, // drain side valid
	input wire logic out_ready_i, // drain side pop
	output logic [W-1:0] out_data_o, // drain data
	output logic [$clog2(DEPTH+1)-1:0] level_o // words held in total
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);
	logic [W-1:0] mem_q [DEPTH]; // storage
	logic [AW-1:0] wp_q; // write pointer
	logic [AW-1:0] rp_q; // read pointer
	logic [CW-1:0] cnt_q; // words in storage
	logic push; // accepted fill
	logic out_take; // drain pops the output word
	logic load; // move storage head into output
	logic [CW-1:0] cnt_d; // next storage count
	logic ov_d; // next output word valid
	logic [CW-1:0] lvl_d; // next total held, output word included
	assign push = in_valid_i && in_ready_o;
	assign out_take = out_valid_o && out_ready_i;
	assign load = (cnt_q != '0) && (!out_valid_o || out_take);
	assign cnt_d = cnt_q + CW'(push) - CW'(load);
	assign ov_d = load || (out_valid_o && !out_take);
	assign lvl_d = cnt_d + CW'(ov_d);
	assign level_o = cnt_q + CW'(out_valid_o);
	// storage write
	always_ff @(posedge clk_sys_i)
	begin
		if (push)
			mem_q[wp_q] <= in_data_i;
	end
	// pointers and count; ready is registered so it reaches the source honestly
	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
		begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
			in_ready_o <= 1'b0;
		end
		else
		begin
			if (push)
				wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
			if (load)
				rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
			cnt_q <= cnt_d;
			// depth counts the output word too, so never more than depth words held
			in_ready_o <= (lvl_d < CW'(DEPTH));
		end
	end
	// registered output word
	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
		begin
			out_valid_o <= 1'b0;
			out_data_o <= '0;
		end
		else if (load)
		begin
			out_valid_o <= 1'b1;
			out_data_o <= mem_q[rp_q];
		end
		else if (out_take)
			out_valid_o <= 1'b0;
	end
endmodule : ddp_fifo

//--- rtl/ddp_pkg.sv
// types shared by the ddr2 pin block: operations, command and beat carriers, states
// no assumptions beyond a systemverilog package scope
package ddp_pkg;
	// memory operations offered to the user
	typedef enum logic [2:0] {
		DDP_OP_NOP = 3'h0,
		DDP_OP_ACT = 3'h1,
		DDP_OP_RD = 3'h2,
		DDP_OP_WR = 3'h3,
		DDP_OP_PRE = 3'h4,
		DDP_OP_REF = 3'h5,
		DDP_OP_LMR = 3'h6
	} ddp_op_t;
	// one command request
	typedef struct packed {
		ddp_op_t op; // operation
		logic [1:0] cs_sel; // external bank index
		logic [2:0] ba; // internal bank or mode register
		logic [15:0] addr; // row/column/mode value
	} ddp_cmd_t;
	// one write beat with its byte masks
	typedef struct packed {
		logic [1:0] mask; // high drops the lane
		logic [15:0] data; // write data
	} ddp_wbeat_t;
	// sequencer states
	typedef enum logic [2:0] {
		DDP_ST_IDLE = 3'b000,
		DDP_ST_CMD = 3'b001,
		DDP_ST_WLAT = 3'b010,
		DDP_ST_WDATA = 3'b011,
		DDP_ST_RWAIT = 3'b100
	} ddp_state_t;
endpackage : ddp_pkg

//--- rtl/ddp_sync.sv
// two flip-flop synchroniser for pins from outside the system clock domain
// assumes inputs are quasi-static per bit; no reset needed
`timescale 1ns/100ps
module ddp_sync #(
	parameter int W = 1
) (
	input wire logic clk_sys_i, // system clock
	input wire logic [W-1:0] d_i, // asynchronous input
	output logic [W-1:0] q_o // synchronised output
);
	logic [W-1:0] meta_q; // first stage, read only by the second
	// two stage capture
	always_ff @(posedge clk_sys_i)
	begin
		meta_q <= d_i;
		q_o <= meta_q;
	end
endmodule : ddp_sync

//--- testbench/ddp_mem_model.sv
// memory partner: decodes commands, stores writes, answers reads
// assumes data and strobe wires resolved against the block's enables
`timescale 1ns/100ps
module ddp_mem_model (
	input wire logic mck_i, // memory clock
	input wire logic [3:0] cs_n_i, // selects
	input wire logic [2:0] rcw_i, // row, column, write strobes
	input wire logic [2:0] ba_i, // bank
	input wire logic [15:0] addr_i, // address
	input wire logic [15:0] dq_i, // data wire
	input wire logic [1:0] dm_i, // masks
	input wire logic [1:0] dqs_i, // strobe wire
	input wire logic wdrv_i, // block drives strobes
	input wire logic silent_i, // withhold read answer
	output logic [25:0] cmd_o, // last command taken
	output logic [15:0] dq_o, // read data
	output logic [1:0] dqs_o, // read strobes
	output logic [1:0] dqs_n_o // read strobes n
);
	logic [15:0] mem [16]; // storage
	logic [3:0] wa [2]; // write pointer per lane
	logic [3:0] ra; // read pointer
	assign dqs_n_o = ~dqs_o;
	initial
	begin
		foreach (mem[i]) mem[i] = 16'h0000;
		dq_o = 16'h0000;
		dqs_o = 2'h0;
		cmd_o = '0;
	end
	// commands on the rising memory clock, ignored when deselected
	always @(posedge mck_i)
	begin
		if (cs_n_i != 4'h0f)
		begin
			cmd_o = {cs_n_i, rcw_i, ba_i, addr_i};
			if (rcw_i == 3'h4)
			begin
				wa[0] = addr_i[3:0];
				wa[1] = addr_i[3:0];
			end
			if (rcw_i == 3'h5 && !silent_i) // strobes driven with read data
			begin
				ra = addr_i[3:0];
				@(posedge mck_i);
				dq_o = mem[ra];
				#41 dqs_o = 2'h3;
				#40 dq_o = mem[ra + 4'h1];
				#40 dqs_o = 2'h0;
				#40 dq_o = ~dq_o; // inverted, no stale data
			end
		end
	end
	// each lane takes its byte on both strobe edges unless masked
	for (genvar l = 0; l < 2; l++)
	begin : g_lane
		always @(posedge dqs_i[l] or negedge dqs_i[l])
		begin
			if (wdrv_i)
			begin
				if (!dm_i[l]) // masked lane kept
					mem[wa[l]][l*8 +: 8] = dq_i[l*8 +: 8];
				wa[l] = wa[l] + 4'h1;
			end
		end
	end
endmodule : ddp_mem_model

//--- testbench/ddp_monitor.sv
// concurrent checks on the ddr2 pin block ports
// assumes binding into ddp_ctrl, one clock domain
`timescale 1ns/100ps
module ddp_monitor (
	input wire logic clk_sys_i, // clock
	input wire logic sys_rst_i, // reset
	input wire logic strobe_diff_i, // strobe mode
	input wire logic cke_en_i, // cke request
	input wire logic odt_en_i, // odt request
	input wire logic cmd_ack_o, // command taken
	input wire logic [1:0] mck_o, // clocks
	input wire logic [1:0] mck_n_o, // clocks n
	input wire logic mck_oe_o, // clock drive
	input wire logic [3:0] cs_n_o, // selects
	input wire logic ras_n_o, // row strobe
	input wire logic cas_n_o, // column strobe
	input wire logic we_n_o, // write enable
	input wire logic [15:0] addr_o, // address
	input wire logic cke_o, // clock enable
	input wire logic odt_o, // termination
	input wire logic dq_oe_o, // data drive
	input wire logic [1:0] dqs_o, // strobes
	input wire logic [1:0] dqs_n_o, // strobes n
	input wire logic dqs_oe_o, // strobe drive
	input wire logic dqs_n_oe_o // strobe n drive
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);
	// command pins held live
	sequence s_live;
		(cs_n_o != 4'h0f) [*8];
	endsequence
	// high half of the memory clock
	sequence s_mck_hi;
		mck_o[0] [*8] ##2 mck_o[0] ##1 !mck_o[0];
	endsequence
	property p_cs_one;
		$countones(~cs_n_o) <= 1;
	endproperty
	a_cs_one: assert property (p_cs_one) else $error("more than one select low");
	property p_nop;
		cs_n_o == 4'h0f |-> {ras_n_o, cas_n_o, we_n_o} == 3'h7;
	endproperty
	a_nop: assert property (p_nop) else $error("deselected but not idle");
	property p_rst;
		disable iff (1'b0) sys_rst_i |=> cs_n_o == 4'h0f && !cke_o && !odt_o && addr_o == 16'h0000 && !dq_oe_o
			&& !dqs_oe_o && !mck_oe_o;
	endproperty
	a_rst: assert property (p_rst) else $error("reset levels wrong");
	property p_cke;
		!$past(sys_rst_i) |-> cke_o == $past(cke_en_i);
	endproperty
	a_cke: assert property (p_cke) else $error("cke not following request");
	property p_odt;
		!$past(sys_rst_i) |-> odt_o == $past(odt_en_i);
	endproperty
	a_odt: assert property (p_odt) else $error("odt not following request");
	property p_mck_diff;
		mck_oe_o && $past(mck_oe_o) |-> mck_n_o == ~mck_o && mck_o[1] == mck_o[0];
	endproperty
	a_mck_diff: assert property (p_mck_diff) else $error("memory clock pair wrong");
	property p_mck_half;
		@(posedge clk_sys_i) disable iff (sys_rst_i || !mck_oe_o) $rose(mck_o[0]) |-> s_mck_hi;
	endproperty
	a_mck_half: assert property (p_mck_half) else $error("memory clock half period wrong");
	property p_ack;
		cmd_ack_o |-> cs_n_o != 4'h0f ##1 s_live;
	endproperty
	a_ack: assert property (p_ack) else $error("command pins not held");
	property p_dq_dqs;
		dq_oe_o == dqs_oe_o;
	endproperty
	a_dq_dqs: assert property (p_dq_dqs) else $error("strobe not with write data");
	property p_dqs_n;
		dqs_n_oe_o == (dqs_oe_o && strobe_diff_i) && (!dqs_n_oe_o || dqs_n_o == ~dqs_o);
	endproperty
	a_dqs_n: assert property (p_dqs_n) else $error("strobe mode wrong");
endmodule : ddp_monitor
bind ddp_ctrl ddp_monitor u_mon (.clk_sys_i, .sys_rst_i, .strobe_diff_i, .cke_en_i, .odt_en_i, .cmd_ack_o,
	.mck_o, .mck_n_o, .mck_oe_o, .cs_n_o, .ras_n_o, .cas_n_o, .we_n_o, .addr_o, .cke_o, .odt_o, .dq_oe_o,
	.dqs_o, .dqs_n_o, .dqs_oe_o, .dqs_n_oe_o);

//--- testbench/tb_ddp_ctrl.sv
// self-checking bench for the ddr2 pin block with a memory partner
// assumes the command and fifo handshakes as handed over
`timescale 1ns/100ps
module tb_ddp_ctrl;
	import ddp_pkg::*;
	logic clk_sys_i = 1'b0, sys_rst_i = 1'b1, mck_en_i = 1'b0, strobe_diff_i = 1'b0; // clock, controls
	logic cke_en_i = 1'b0, odt_en_i = 1'b0, cmd_valid_i = 1'b0, wr_valid_i = 1'b0, silent = 1'b0; // requests
	ddp_cmd_t cmd_i = '0; // command
	ddp_wbeat_t wr_i = '0; // write beat
	logic cmd_ack_o, wr_ready_o, rd_valid_o, rd_timeout_o, mck_oe_o, ctl_oe_o, ras_n_o, cas_n_o, we_n_o;
	logic cke_o, odt_o, dq_oe_o, dqs_oe_o, dqs_n_oe_o;
	logic [31:0] rd_data_o, got; // read word
	logic [1:0] mck_o, mck_n_o, dm_o, dqs_o, dqs_n_o, m_dqs, m_dqs_n, dqs_w, dqs_n_w;
	logic [3:0] cs_n_o;
	logic [2:0] ba_o;
	logic [15:0] addr_o, dq_o, m_dq, dq_w, exp_mem [16]; // exp_mem: bench copy of memory
	logic [25:0] m_cmd;
	logic [2:0] enc [7] = '{3'h7, 3'h3, 3'h5, 3'h4, 3'h2, 3'h1, 3'h0}; // strobes per op
	ddp_op_t ol [7] = '{DDP_OP_ACT, DDP_OP_PRE, DDP_OP_REF, DDP_OP_LMR, DDP_OP_LMR, DDP_OP_LMR, DDP_OP_LMR};
	int err_total = 0, total_checks = 0, n;
	always #4 clk_sys_i = ~clk_sys_i;
	// wire levels from all drivers
	assign dq_w = dq_oe_o ? dq_o : m_dq;
	assign dqs_w = dqs_oe_o ? dqs_o : m_dqs;
	assign dqs_n_w = dqs_n_oe_o ? dqs_n_o : m_dqs_n;
	ddp_ctrl dut (.clk_sys_i, .sys_rst_i, .mck_en_i, .strobe_diff_i, .cke_en_i, .odt_en_i, .cmd_valid_i, .cmd_i,
		.cmd_ack_o, .wr_valid_i, .wr_i, .wr_ready_o, .rd_valid_o, .rd_data_o, .rd_timeout_o, .mck_o, .mck_n_o,
		.mck_oe_o, .cs_n_o, .ras_n_o, .cas_n_o, .we_n_o, .ba_o, .addr_o, .ctl_oe_o, .cke_o, .odt_o, .dq_o,
		.dq_oe_o, .dq_i(dq_w), .dm_o, .dqs_o, .dqs_n_o, .dqs_oe_o, .dqs_n_oe_o, .dqs_i(dqs_w), .dqs_n_i(dqs_n_w));
	ddp_mem_model u_mem (.mck_i(mck_o[0]), .cs_n_i(cs_n_o), .rcw_i({ras_n_o, cas_n_o, we_n_o}), .ba_i(ba_o),
		.addr_i(addr_o), .dq_i(dq_w), .dm_i(dm_o), .dqs_i(dqs_w), .wdrv_i(dqs_oe_o), .silent_i(silent),
		.cmd_o(m_cmd), .dq_o(m_dq), .dqs_o(m_dqs), .dqs_n_o(m_dqs_n));
	task chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask : chk
	task end_sim;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_sim
	task cyc(input int c);
		repeat (c) @(posedge clk_sys_i);
		#1;
	endtask : cyc
	// bounded wait: 0 ack, 1 read word, 2 timeout, 3 fifo ready
	task wait_hi(input int s);
		logic f;
		for (int i = 0; i < 400; i++)
		begin
			@(posedge clk_sys_i);
			f = s == 0 ? cmd_ack_o : s == 1 ? rd_valid_o : s == 2 ? rd_timeout_o : wr_ready_o;
			got = rd_data_o;
			if (f === 1'b1)
				break;
		end
		total_checks++;
		if (f !== 1'b1)
		begin
			err_total++;
			$display("[FAIL] %0t wait ran out", $time);
			end_sim();
		end
		#1;
	endtask : wait_hi
	task send(input ddp_op_t op, input logic [2:0] ba, input logic [15:0] a);
		cmd_i = '{op, 2'($urandom), ba, a};
		cmd_valid_i = 1'b1;
		wait_hi(0);
		cmd_valid_i = 1'b0;
		cyc(1);
	endtask : send
	task rd_chk(input logic [3:0] a);
		send(DDP_OP_RD, 3'h0, {12'h000, a});
		wait_hi(1);
		chk(got, {exp_mem[a + 4'h1], exp_mem[a]}); // lanes and masks
	endtask : rd_chk
	// two random beats with random masks, written then read back
	task wr_rd(input logic [3:0] a);
		logic [17:0] b;
		logic [3:0] x;
		wr_valid_i = 1'b1;
		for (int i = 0; i < 2; i++)
		begin
			b = 18'($urandom);
			x = a + 4'(i);
			wr_i = b;
			wait_hi(3);
			for (int l = 0; l < 2; l++)
				if (!b[16 + l])
					exp_mem[x][l*8 +: 8] = b[l*8 +: 8];
		end
		wr_valid_i = 1'b0;
		send(DDP_OP_WR, 3'h0, {12'h000, a});
		rd_chk(a);
	endtask : wr_rd
	initial
	begin
		void'($urandom(32'h0000_115a));
		foreach (exp_mem[i]) exp_mem[i] = 16'h0000;
		cyc(20);
		sys_rst_i = 1'b0;
		cyc(1);
		chk({cs_n_o, cke_o, addr_o, dq_oe_o, ctl_oe_o}, {4'hf, 1'h0, 16'h0000, 1'h0, 1'h1});
		mck_en_i = 1'b1;
		cyc(2);
		// every plain command, each mode register once
		for (int i = 0; i < 7; i++)
		begin
			cke_en_i = 1'($urandom);
			odt_en_i = 1'($urandom);
			send(ol[i], i < 3 ? 3'($urandom) : 3'(i - 3), 16'($urandom));
			cyc(30);
			chk(m_cmd, {~(4'h1 << cmd_i.cs_sel), enc[ol[i]], cmd_i.ba, cmd_i.addr});
			chk({cke_o, odt_o}, {cke_en_i, odt_en_i});
		end
		$display("command test done");
		for (int m = 0; m < 2; m++)
		begin
			strobe_diff_i = 1'(m);
			repeat (2) wr_rd(4'($urandom));
		end
		$display("write read test done");
		// fifo fills while commands wait for the memory clock
		mck_en_i = 1'b0;
		cyc(30);
		wr_valid_i = 1'b1;
		n = 0;
		repeat (12)
		begin
			wr_i = {2'h0, 16'h5a00 + 16'(n)};
			@(posedge clk_sys_i);
			if (wr_ready_o === 1'b1)
				n++;
			#1;
		end
		wr_valid_i = 1'b0;
		chk(n, 8);
		mck_en_i = 1'b1;
		for (int k = 0; k < 8; k++)
			exp_mem[k] = 16'h5a00 + 16'(k);
		for (int k = 0; k < 4; k++)
			send(DDP_OP_WR, 3'h0, 16'(2 * k));
		rd_chk(4'h6);
		chk(wr_ready_o, 1);
		$display("fifo test done");
		silent = 1'b1;
		send(DDP_OP_RD, 3'h0, 16'h0000);
		wait_hi(2);
		silent = 1'b0;
		$display("timeout test done");
		end_sim();
	end
endmodule : tb_ddp_ctrl
